// ==== hdl/mcx_core.sv ====
// Purpose: Machine-cycle sequencer with stretchable external data moves
// Assumes: Instruction decode supplies the cycle count at each fetch
// Notes: Data from the external bus pins is sampled on the rising edge, then captured on the falling edge
`timescale 1ns/1ps

// Behaviour
// - Machine cycle is four clock states
// - States run one, two, three, four
// - Both clock edges used for timing
// - One op-code fetch per machine cycle, none in external move access cycles
// - Single-cycle ops finish in four clocks
// - Some one-byte ops take two cycles
// - Other ops take three to five cycles
// - External move lasts two to nine cycles
// - Strobe widens with added stretch cycles
// - Indirect form: low byte from register
// - Indirect form: high byte from port-two latch
// - Pointer form: address from selected pointer
// - Select bit is bit zero at 86h
// - Other select bits ignored, read zero
// - Select zero primary, one secondary pointer
// - Stretch held in clock control bits 2-0
// - Stretch resets to one, three cycles
// - Move starts with ordinary fetch cycle
// - Stretch affects only external moves
module mcx_core
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic [2:0] i_op_cycles,
  input wire logic i_op_xmove,
  input wire logic i_xm_write,
  input wire logic i_xm_ptr_form,
  input wire logic [7:0] i_ri_value,
  input wire logic [7:0] i_port2_latch,
  input wire logic i_dp_load,
  input wire logic [15:0] i_dp_load_data,
  input wire logic i_dp_inc,
  input wire logic [7:0] i_xdata_pin,
  output mcx_pkg::mcx_state_t o_state,
  output logic o_fetch,
  output logic o_instr_start,
  output logic [15:0] o_xaddr,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [7:0] o_rdata,
  output logic o_rdata_valid
);
  import mcx_pkg::*;

  mcx_dp_if dp ();

  mcx_state_t st_q, st_d;
  logic [3:0] cyc_q, cyc_d;
  logic [3:0] len_q, len_d;
  logic xm_q, xm_d;
  logic wr_q, wr_d;
  logic [15:0] addr_q, addr_d;
  logic [2:0] stretch_q, stretch_d;
  logic strobe_q, strobe_d;
  logic [7:0] pin_s1_q, pin_s2_q;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic last_cyc;
  logic access;
  logic [2:0] op_len;

  // ----------------------------------------------------------------
  // Strobe window decode
  // ----------------------------------------------------------------
  // Window follows the latched length, so a stretch write mid-move cannot reshape it
  function automatic logic strobe_at(input mcx_state_t st, input logic [3:0] cyc, input logic [3:0] len);
    if (cyc == 4'h0)
      return 1'b0;
    else if (len == MCX_XMOVE_BASE_CYCLES)
      return (st == MCX_STATE_TWO) || (st == MCX_STATE_THREE);
    else if (cyc == 4'h1)
      return (st == MCX_STATE_THREE) || (st == MCX_STATE_FOUR);
    else if (cyc == len - 4'h1)
      return (st == MCX_STATE_ONE) || (st == MCX_STATE_TWO);
    else
      return 1'b1;
  endfunction

  // ----------------------------------------------------------------
  // Pointer bank and register port
  // ----------------------------------------------------------------
  mcx_primary_data_pointer u_primary_data_pointer
  (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .dp(dp.regs)
  );

  assign dp.sel_wr = i_sfr_wr && (i_sfr_addr == MCX_PTR_SEL_ADDR);
  assign dp.sel_wdata = i_sfr_wdata;
  assign dp.ld = i_dp_load;
  assign dp.ld_data = i_dp_load_data;
  assign dp.inc = i_dp_inc;

  always_comb
  begin
    stretch_d = stretch_q;
    if (i_sfr_wr && (i_sfr_addr == MCX_CLK_CTRL_ADDR))
      stretch_d = i_sfr_wdata[MCX_STRETCH_MSB:0];
    if (i_sfr_addr == MCX_PTR_SEL_ADDR)
      o_sfr_rdata = dp.sel_rdata;
    else if (i_sfr_addr == MCX_CLK_CTRL_ADDR)
      o_sfr_rdata = {5'h00, stretch_q};
    else
      o_sfr_rdata = 8'h00;
  end

  // ----------------------------------------------------------------
  // Machine-cycle sequencer
  // ----------------------------------------------------------------
  assign last_cyc = (cyc_q == len_q - 4'h1);
  assign access = xm_q && (cyc_q != 4'h0);
  assign op_len = (i_op_cycles < MCX_MIN_CYCLES) ? MCX_MIN_CYCLES :
                  (i_op_cycles > MCX_MAX_CYCLES) ? MCX_MAX_CYCLES : i_op_cycles;

  always_comb
  begin
    st_d = st_q;
    cyc_d = cyc_q;
    len_d = len_q;
    xm_d = xm_q;
    wr_d = wr_q;
    addr_d = addr_q;
    case (st_q)
      MCX_STATE_ONE: st_d = MCX_STATE_TWO;
      MCX_STATE_TWO: st_d = MCX_STATE_THREE;
      MCX_STATE_THREE: st_d = MCX_STATE_FOUR;
      default:
      begin
        st_d = MCX_STATE_ONE;
        cyc_d = last_cyc ? 4'h0 : cyc_q + 4'h1;
      end
    endcase
    if ((st_q == MCX_STATE_ONE) && (cyc_q == 4'h0))
    begin
      xm_d = i_op_xmove;
      wr_d = i_xm_write;
      if (i_op_xmove)
        len_d = MCX_XMOVE_BASE_CYCLES + {1'b0, stretch_q};
      else
        len_d = {1'b0, op_len};
      if (i_xm_ptr_form)
        addr_d = dp.ptr;
      else
        addr_d = {i_port2_latch, i_ri_value};
    end
    strobe_d = xm_d && strobe_at(st_d, cyc_d, len_d);
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_q <= MCX_STATE_ONE;
      cyc_q <= 4'h0;
      len_q <= MCX_RESET_LEN;
      xm_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= MCX_PTR_RESET;
      stretch_q <= MCX_STRETCH_RESET;
      strobe_q <= 1'b0;
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      cyc_q <= cyc_d;
      len_q <= len_d;
      xm_q <= xm_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      stretch_q <= stretch_d;
      strobe_q <= strobe_d;
      pin_s1_q <= i_xdata_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Read data capture on the falling edge
  // ----------------------------------------------------------------
  always_comb
  begin
    rvalid_d = strobe_q && !wr_q && !strobe_d;
    rdata_d = rvalid_d ? pin_s2_q : rdata_q;
  end

  always_ff @(negedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign o_state = st_q;
  assign o_fetch = (st_q == MCX_STATE_ONE) && !access;
  assign o_instr_start = (st_q == MCX_STATE_ONE) && (cyc_q == 4'h0);
  assign o_xaddr = addr_q;
  assign o_rd_n = !(strobe_q && !wr_q);
  assign o_wr_n = !(strobe_q && wr_q);
  assign o_rdata = rdata_q;
  assign o_rdata_valid = rvalid_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_state_order;
    @(posedge i_clk) disable iff (!i_resetn)
    (st_q == MCX_STATE_ONE) |=> (st_q == MCX_STATE_TWO) ##1 (st_q == MCX_STATE_THREE)
      ##1 (st_q == MCX_STATE_FOUR) ##1 (st_q == MCX_STATE_ONE);
  endproperty
  a_state_order: assert property (p_state_order)
    else $error("machine cycle state order broken");

  property p_xmove_len;
    @(posedge i_clk) disable iff (!i_resetn)
    (o_instr_start && i_op_xmove) |=> (len_q == 4'h2 + {1'b0, $past(stretch_q)});
  endproperty
  a_xmove_len: assert property (p_xmove_len)
    else $error("external move length not two plus stretch");

  property p_other_len;
    @(posedge i_clk) disable iff (!i_resetn)
    (o_instr_start && !i_op_xmove && (i_op_cycles >= 3'h1) && (i_op_cycles <= 3'h5))
      |=> (len_q == {1'b0, $past(i_op_cycles)});
  endproperty
  a_other_len: assert property (p_other_len)
    else $error("instruction length changed by stretch");

  property p_strobe_zero;
    @(posedge i_clk) disable iff (!i_resetn)
    ($fell(o_rd_n) && (len_q == MCX_XMOVE_BASE_CYCLES)) |-> !o_rd_n [*2] ##1 o_rd_n;
  endproperty
  a_strobe_zero: assert property (p_strobe_zero)
    else $error("unstretched strobe not two clocks");

  property p_strobe_one;
    @(posedge i_clk) disable iff (!i_resetn)
    ($fell(o_wr_n) && (len_q == MCX_XMOVE_BASE_CYCLES + 4'h1)) |-> !o_wr_n [*4] ##1 o_wr_n;
  endproperty
  a_strobe_one: assert property (p_strobe_one)
    else $error("stretch one strobe not four clocks");

  property p_fetch_then_access;
    @(posedge i_clk) disable iff (!i_resetn)
    $fell(o_rd_n) |-> access && (cyc_q == 4'h1) && !o_fetch;
  endproperty
  a_fetch_then_access: assert property (p_fetch_then_access)
    else $error("strobe outside the cycle after fetch");

  property p_indirect_addr;
    @(posedge i_clk) disable iff (!i_resetn)
    (o_instr_start && !i_xm_ptr_form) |=> (o_xaddr == {$past(i_port2_latch), $past(i_ri_value)});
  endproperty
  a_indirect_addr: assert property (p_indirect_addr)
    else $error("indirect address bytes wrong");

  property p_ptr_addr;
    @(posedge i_clk) disable iff (!i_resetn)
    (o_instr_start && i_xm_ptr_form) |=> (o_xaddr == $past(dp.ptr));
  endproperty
  a_ptr_addr: assert property (p_ptr_addr)
    else $error("pointer address wrong");

  property p_stretch_rd;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_sfr_wr && (i_sfr_addr == MCX_CLK_CTRL_ADDR)) |=>
      (stretch_q == $past(i_sfr_wdata[2:0]));
  endproperty
  a_stretch_rd: assert property (p_stretch_rd)
    else $error("stretch field not written");

  property p_reset_state;
    @(posedge i_clk) $rose(i_resetn) |-> (st_q == MCX_STATE_ONE) && (stretch_q == 3'h1);
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("reset values wrong");
endmodule

// ==== hdl/mcx_pkg.sv ====
// Purpose: Shared constants and types for the machine-cycle sequencer
// Assumes: Special function registers sit on an 8-bit internal address
// Notes: Lengths are counted in machine cycles of four states
package mcx_pkg;

  typedef enum logic [1:0]
  {
    MCX_STATE_ONE   = 2'b00,
    MCX_STATE_TWO   = 2'b01,
    MCX_STATE_THREE = 2'b10,
    MCX_STATE_FOUR  = 2'b11
  } mcx_state_t;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] MCX_PTR_SEL_ADDR = 8'h86;
  localparam logic [7:0] MCX_CLK_CTRL_ADDR = 8'h8e;
  localparam logic [7:0] MCX_PTR_SEL_RESET = 8'h00;
  localparam logic [2:0] MCX_STRETCH_RESET = 3'h1;
  localparam int MCX_PTR_SEL_BIT = 0;
  localparam int MCX_STRETCH_MSB = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int MCX_STATES_PER_CYCLE = 4;
  localparam logic [3:0] MCX_XMOVE_BASE_CYCLES = 4'h2;
  localparam logic [2:0] MCX_MIN_CYCLES = 3'h1;
  localparam logic [2:0] MCX_MAX_CYCLES = 3'h5;
  localparam logic [3:0] MCX_RESET_LEN = 4'h1;
  localparam logic [15:0] MCX_PTR_RESET = 16'h0000;

endpackage

// ==== hdl/mcx_dp_if.sv ====
// Purpose: Carrier between the sequencer and its data pointer bank
// Assumes: One clock domain
// Notes: The core drives requests, the pointer bank answers
`timescale 1ns/1ps
interface mcx_dp_if;
  logic sel_wr;
  logic [7:0] sel_wdata;
  logic [7:0] sel_rdata;
  logic ld;
  logic [15:0] ld_data;
  logic inc;
  logic [15:0] ptr;

  modport core
  (
    output sel_wr, sel_wdata, ld, ld_data, inc,
    input sel_rdata, ptr
  );
  modport regs
  (
    input sel_wr, sel_wdata, ld, ld_data, inc,
    output sel_rdata, ptr
  );
endinterface

// ==== hdl/mcx_primary_data_pointer.sv ====
// Purpose: Two 16-bit data pointers and their select register
// Assumes: Core raises at most one of load or increment per cycle
// Notes: Load and increment act on the pointer chosen by the select bit
`timescale 1ns/1ps
module mcx_primary_data_pointer
(
  input wire logic i_clk,
  input wire logic i_resetn,
  mcx_dp_if.regs dp
);
  import mcx_pkg::*;

  logic sel_q;
  logic sel_d;
  logic [15:0] ptr_q [2];
  logic [15:0] ptr_d [2];

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  always_comb
  begin
    sel_d = sel_q;
    if (dp.sel_wr)
    begin
      sel_d = dp.sel_wdata[MCX_PTR_SEL_BIT];
    end
  end

  for (genvar g = 0; g < 2; g++)
  begin : g_ptr
    always_comb
    begin
      ptr_d[g] = ptr_q[g];
      if (sel_q == 1'(g))
      begin
        if (dp.ld)
        begin
          ptr_d[g] = dp.ld_data;
        end
        else if (dp.inc)
        begin
          ptr_d[g] = ptr_q[g] + 16'h0001;
        end
      end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
      if (!i_resetn)
      begin
        ptr_q[g] <= MCX_PTR_RESET;
      end
      else
      begin
        ptr_q[g] <= ptr_d[g];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sel_q <= MCX_PTR_SEL_RESET[MCX_PTR_SEL_BIT];
    end
    else
    begin
      sel_q <= sel_d;
    end
  end

  assign dp.sel_rdata = {7'h00, sel_q};
  assign dp.ptr = sel_q ? ptr_q[1] : ptr_q[0];

  property p_ptr_choice;
    @(posedge i_clk) disable iff (!i_resetn)
    (dp.sel_wr && !dp.ld && !dp.inc) |=>
      (dp.ptr == ($past(dp.sel_wdata[0]) ? $past(ptr_q[1]) : $past(ptr_q[0])));
  endproperty
  a_ptr_choice: assert property (p_ptr_choice)
    else $error("pointer output does not follow select bit");

  property p_sel_upper;
    @(posedge i_clk) disable iff (!i_resetn)
    dp.sel_wr |=> (dp.sel_rdata[7:1] == 7'h00) && (dp.sel_rdata[0] == $past(dp.sel_wdata[0]));
  endproperty
  a_sel_upper: assert property (p_sel_upper)
    else $error("select register write not as expected");
endmodule

// ==== verif/mcx_xmem_model.sv ====
// Purpose: External data memory model on the far side of the core
// Assumes: Read data is a function of the address; bus never floats, it toggles when not read
// Notes: A released bus toggles every clock so stale data never passes
`timescale 1ns/1ps
module mcx_xmem_model
(
  input wire logic i_clk,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [15:0] i_addr,
  output logic [7:0] o_data,
  output logic [15:0] o_last_wr
);
  initial
  begin
    o_data = 8'h00;
    o_last_wr = 16'h0000;
  end

  always @(posedge i_clk or negedge i_rd_n)
  begin
    if (!i_rd_n)
      o_data <= i_addr[7:0] ^ 8'h5a;
    else
      o_data <= ~o_data;
  end

  // Write lands at the end of the strobe
  always @(posedge i_wr_n)
    o_last_wr <= i_addr;
endmodule

// ==== verif/mcx_core_tb_top.sv ====
// Purpose: Self-checking bench for the machine-cycle sequencer
// Assumes: Inputs change 1 ns after the rising clock edge
// Notes: Counts clocks, fetches and strobe width of every instruction
`timescale 1ns/1ps
module mcx_core_tb_top;
  import mcx_pkg::*;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00;
  logic i_sfr_wr = 1'b0;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic [2:0] i_op_cycles = 3'h0;
  logic i_op_xmove = 1'b0;
  logic i_xm_write = 1'b0;
  logic i_xm_ptr_form = 1'b0;
  logic [7:0] i_ri_value = 8'h00;
  logic [7:0] i_port2_latch = 8'h00;
  logic i_dp_load = 1'b0;
  logic [15:0] i_dp_load_data = 16'h0000;
  logic i_dp_inc = 1'b0;
  logic [7:0] pin;
  logic [15:0] last_wr;
  logic [7:0] o_sfr_rdata;
  mcx_state_t o_state;
  logic o_fetch;
  logic o_instr_start;
  logic [15:0] o_xaddr;
  logic o_rd_n;
  logic o_wr_n;
  logic [7:0] o_rdata;
  logic o_rdata_valid;
  int fails = 0;
  int checks = 0;

  always #10 i_clk = ~i_clk;

  mcx_core mcx_core_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
    .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .i_op_cycles(i_op_cycles), .i_op_xmove(i_op_xmove),
    .i_xm_write(i_xm_write), .i_xm_ptr_form(i_xm_ptr_form), .i_ri_value(i_ri_value),
    .i_port2_latch(i_port2_latch), .i_dp_load(i_dp_load), .i_dp_load_data(i_dp_load_data), .i_dp_inc(i_dp_inc),
    .i_xdata_pin(pin), .o_state(o_state), .o_fetch(o_fetch), .o_instr_start(o_instr_start),
    .o_xaddr(o_xaddr), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid));

  mcx_xmem_model mcx_xmem_model_i (.i_clk(i_clk), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n), .i_addr(o_xaddr),
    .o_data(pin), .o_last_wr(last_wr));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task tick;
    @(posedge i_clk);
    #1;
  endtask

  task sfr_wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    tick;
    i_sfr_wr = 1'b0;
    tick;
  endtask

  task sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    i_sfr_addr = a;
    #1;
    chk(16'(o_sfr_rdata), 16'(exp));
  endtask

  task dp_pulse(input logic ld, input logic inc, input logic [15:0] d);
    i_dp_load = ld;
    i_dp_inc = inc;
    i_dp_load_data = d;
    tick;
    i_dp_load = 1'b0;
    i_dp_inc = 1'b0;
    tick;
  endtask

  // Runs one instruction and measures it up to the next start
  task run_op(input logic [2:0] cyc, input logic xm, input logic wr, input logic pf, input logic [7:0] ri,
    input logic [7:0] p2, input int len, input int str, input logic [15:0] addr);
    int n;
    int s;
    int f;
    int v;
    n = 0;
    while (o_instr_start !== 1'b1 && n < 40)
    begin
      tick;
      n++;
    end
    if (n >= 40)
    begin
      fails++;
      give_verdict;
    end
    i_op_cycles = cyc;
    i_op_xmove = xm;
    i_xm_write = wr;
    i_xm_ptr_form = pf;
    i_ri_value = ri;
    i_port2_latch = p2;
    n = 0;
    s = 0;
    f = 0;
    v = 0;
    do
    begin
      chk(16'(o_state), 16'(n % 4));
      if (o_fetch === 1'b1)
        f++;
      if (o_rd_n === 1'b0 || o_wr_n === 1'b0)
        s++;
      if (o_rdata_valid === 1'b1)
        v++;
      tick;
      n++;
    end
    while (o_instr_start !== 1'b1 && n < 60);
    if (n >= 60)
    begin
      fails++;
      give_verdict;
    end
    chk(16'(n), 16'(len * 4));
    chk(16'(f), xm ? 16'h0001 : 16'(len));
    chk(16'(s), 16'(str));
    if (xm)
      chk(o_xaddr, addr);
    if (xm && wr)
      chk(last_wr, addr);
    if (xm && !wr && str > 2)
    begin
      chk(16'(v), 16'h0001);
      chk(16'(o_rdata), 16'(addr[7:0] ^ 8'h5a));
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge i_clk);
    #1;
    i_resetn = 1'b1;
    sfr_rd(MCX_PTR_SEL_ADDR, 8'h00);
    sfr_rd(MCX_CLK_CTRL_ADDR, 8'h01);
    sfr_rd(8'h55, 8'h00);
    run_op(3'h0, 1'b1, 1'b0, 1'b0, 8'h3c, 8'h7e, 3, 4, 16'h7e3c);
    for (int c = 0; c < 8; c++)
      run_op(3'(c), 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, c < 1 ? 1 : (c > 5 ? 5 : c), 0, 16'h0000);
    sfr_wr(MCX_PTR_SEL_ADDR, 8'hff);
    sfr_rd(MCX_PTR_SEL_ADDR, 8'h01);
    sfr_wr(MCX_PTR_SEL_ADDR, 8'h00);
    sfr_wr(MCX_CLK_CTRL_ADDR, 8'hf9);
    sfr_rd(MCX_CLK_CTRL_ADDR, 8'h01);
    dp_pulse(1'b1, 1'b0, 16'h1234);
    sfr_wr(MCX_PTR_SEL_ADDR, 8'h01);
    dp_pulse(1'b1, 1'b0, 16'habcd);
    run_op(3'h1, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1, 0, 16'h0000);
    run_op(3'h0, 1'b1, 1'b0, 1'b1, 8'h11, 8'h22, 3, 4, 16'habcd);
    sfr_wr(MCX_PTR_SEL_ADDR, 8'h02);
    sfr_rd(MCX_PTR_SEL_ADDR, 8'h00);
    run_op(3'h1, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1, 0, 16'h0000);
    run_op(3'h0, 1'b1, 1'b0, 1'b1, 8'h11, 8'h22, 3, 4, 16'h1234);
    dp_pulse(1'b0, 1'b1, 16'h0000);
    run_op(3'h1, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1, 0, 16'h0000);
    run_op(3'h0, 1'b1, 1'b1, 1'b1, 8'h11, 8'h22, 3, 4, 16'h1235);
    for (int st = 0; st < 8; st++)
    begin
      sfr_wr(MCX_CLK_CTRL_ADDR, 8'(st));
      sfr_rd(MCX_CLK_CTRL_ADDR, 8'(st));
      run_op(3'h2, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 2, 0, 16'h0000);
      run_op(3'h1, 1'b1, st[0], 1'b0, 8'(st * 17), 8'hc0, 2 + st, st == 0 ? 2 : 4 * st,
        {8'hc0, 8'(st * 17)});
    end
    i_resetn = 1'b0;
    #1;
    chk(16'(o_state), 16'(MCX_STATE_ONE));
    repeat (2) tick;
    chk(16'(o_state), 16'(MCX_STATE_ONE));
    chk(16'(o_instr_start), 16'h0001);
    sfr_rd(MCX_CLK_CTRL_ADDR, 8'h01);
    sfr_rd(MCX_PTR_SEL_ADDR, 8'h00);
    i_resetn = 1'b1;
    tick;
    chk(16'(o_state), 16'(MCX_STATE_TWO));
    give_verdict;
  end
endmodule
